// ---- srs_params.svh ----
/*
  constants of the speed reference selector: thresholds, reset values, timing.
  assumes remote current codes in units of 0.01 ma.
*/
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

`define SRS_REF_W 16
`define SRS_MA_W 12
`define SRS_SYNC_W 6
`define SRS_MA_SEL 12'h0c8
`define SRS_MA_LOW 12'h190
`define SRS_MA_HIGH 12'h7d0
`define SRS_MA_SPAN 30'sh640
`define SRS_REF_RST 16'h0000
`define SRS_CLK_MHZ 100
`define SRS_TICK_US 1000
`define SRS_TICK_CYCLES (`SRS_TICK_US * `SRS_CLK_MHZ)

`endif

// ---- srs_pkg.sv ----
/*
  types of the speed reference selector.
  assumes srs_params.svh is on the include path.
*/
`include "srs_params.svh"

package srs_pkg;
  typedef logic [`SRS_REF_W-1:0] srs_ref_t;
  typedef logic [`SRS_MA_W-1:0] srs_ma_t;
  typedef enum logic [1:0] {SRS_DIAG, SRS_RUN, SRS_FAILED} srs_state_t;
endpackage : srs_pkg

// ---- srs_ramp_if.sv ----
/*
  carrier between the selector and its ramp generator.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface srs_ramp_if;
  import srs_pkg::*;
  srs_ref_t target;
  srs_ref_t step_up;
  srs_ref_t step_dn;
  logic tick;
  srs_ref_t ref_q;
  modport ctl (output target, output step_up, output step_dn, output tick, input ref_q);
  modport ramp (input target, input step_up, input step_dn, input tick, output ref_q);
endinterface : srs_ramp_if

// ---- srs_ramp.sv ----
/*
  rate-limited speed reference ramp, one step per update tick.
  assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "srs_params.svh"

module srs_ramp (
  input wire logic clk,
  input wire logic rst_n,
  srs_ramp_if.ramp r
);
  import srs_pkg::*;

  srs_ref_t ref_q;
  srs_ref_t next_ref;

  always_comb begin
    next_ref = ref_q;
    if (r.tick) begin
      if (r.target > ref_q) begin
        next_ref = ((r.target - ref_q) > r.step_up) ? srs_ref_t'(ref_q + r.step_up) : r.target;
      end else if (r.target < ref_q) begin
        next_ref = ((ref_q - r.target) > r.step_dn) ? srs_ref_t'(ref_q - r.step_dn) : r.target;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= `SRS_REF_RST;
    end else begin
      ref_q <= next_ref;
    end
  end

  assign r.ref_q = ref_q;

  property p_hold_between_ticks;
    @(posedge clk) disable iff (!rst_n) !r.tick |=> ref_q == $past(ref_q);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("ref moved without tick");

  property p_step_bounded;
    @(posedge clk) disable iff (!rst_n)
      r.tick |=> (ref_q >= $past(ref_q)) ? (ref_q - $past(ref_q) <= $past(r.step_up))
                                        : ($past(ref_q) - ref_q <= $past(r.step_dn));
  endproperty
  a_step_bounded: assert property (p_step_bounded) else $error("ramp step exceeds rate");

  property p_no_overshoot;
    @(posedge clk) disable iff (!rst_n)
      r.tick && r.target >= ref_q |=> ref_q <= $past(r.target);
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("ramp overshot target");
endmodule : srs_ramp

// ---- srs_top.sv ----
/*
  speed reference selection and fuel enable of an engine speed governor.
  Summary below; switch pins are asynchronous, remote current, speed-loss
  flag and diagnostic result come from logic on clk.
*/
// Summary of operation
// - four notch bits select one of sixteen references
// - switch voltage present reads one, absent zero
// - input d is msb, input a lsb
// - minimum-fuel input low forces minimum fuel
// - speed loss forces minimum fuel without override
// - override suppresses speed-loss shutdown for cranking
// - remote current of 2 ma selects remote
// - 2 to 4 ma ramps to 4 ma setpoint
// - 4 to 20 ma interpolates, rate limited
// - below 2 ma ramps to notch reference
// - failed power-up diagnostics turn output off
`timescale 1ns/1ps
`include "srs_params.svh"

module srs_top #(
  parameter int unsigned TICK_CYCLES = `SRS_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic notch_a_pin,
  input wire logic notch_b_pin,
  input wire logic notch_c_pin,
  input wire logic notch_d_pin,
  input wire logic run_enable_pin,
  input wire logic speed_fail_override_pin,
  input wire logic speed_signal_lost,
  input wire logic diag_done,
  input wire logic diag_pass,
  input wire logic remote_valid,
  input wire srs_pkg::srs_ma_t remote_ma,
  input wire logic remote_fail,
  input wire logic table_wr,
  input wire logic [3:0] table_idx,
  input wire srs_pkg::srs_ref_t table_data,
  input wire srs_pkg::srs_ref_t accel_step,
  input wire srs_pkg::srs_ref_t decel_step,
  input wire srs_pkg::srs_ref_t raise_step,
  input wire srs_pkg::srs_ref_t lower_step,
  input wire srs_pkg::srs_ref_t remote_ref_4ma,
  input wire srs_pkg::srs_ref_t remote_ref_20ma,
  output srs_pkg::srs_ref_t speed_ref,
  output logic [3:0] notch_code,
  output logic remote_active,
  output logic fuel_enable,
  output logic actuator_off,
  output srs_pkg::srs_state_t diag_state
);
  import srs_pkg::*;

  // two-stage synchronisers for the switch pins
  logic [`SRS_SYNC_W-1:0] pins;
  logic [`SRS_SYNC_W-1:0] sync1;
  logic [`SRS_SYNC_W-1:0] sync2;
  logic [`SRS_SYNC_W-1:0] next_sync1;
  logic [`SRS_SYNC_W-1:0] next_sync2;
  assign pins = {speed_fail_override_pin, run_enable_pin,
                 notch_d_pin, notch_c_pin, notch_b_pin, notch_a_pin};

  // only the second stage reads the first
  always_comb begin
    next_sync1 = pins;
    next_sync2 = sync1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  logic run_sw;
  logic ovr_sw;
  assign run_sw = sync2[4];
  assign ovr_sw = sync2[5];

  // notch reference table
  srs_ref_t notch_tbl [16];
  srs_ref_t next_tbl [16];

  always_comb begin
    next_tbl = notch_tbl;
    if (table_wr) begin
      next_tbl[table_idx] = table_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        notch_tbl[i] <= `SRS_REF_RST;
      end
    end else begin
      notch_tbl <= next_tbl;
    end
  end

  // sampled remote current and update tick
  srs_ma_t ma_q;
  srs_ma_t next_ma;
  logic rfail_q;
  logic next_rfail;
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic tick;
  logic next_tick;

  always_comb begin
    next_ma = remote_valid ? remote_ma : ma_q;
    next_rfail = remote_fail;
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h1;
    if (tick_cnt >= TICK_CYCLES - 1) begin
      next_tick_cnt = 32'h0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ma_q <= 12'h000;
      rfail_q <= 1'b1;
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      ma_q <= next_ma;
      rfail_q <= next_rfail;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // target selection
  srs_ramp_if rif ();
  logic sel_remote;
  srs_ref_t remote_target;
  logic [10:0] span_pos;
  logic signed [17:0] span_delta;
  logic signed [29:0] span_prod;
  logic signed [29:0] span_scaled;

  always_comb begin
    span_pos = 11'h000;
    span_delta = 18'(signed'({2'b00, remote_ref_20ma}) - signed'({2'b00, remote_ref_4ma}));
    span_prod = 30'sh0;
    span_scaled = 30'sh0;
    sel_remote = !rfail_q && (ma_q >= `SRS_MA_SEL);
    if (ma_q < `SRS_MA_LOW) begin
      remote_target = remote_ref_4ma;
    end else if (ma_q >= `SRS_MA_HIGH) begin
      remote_target = remote_ref_20ma;
    end else begin
      span_pos = 11'(ma_q - `SRS_MA_LOW);
      span_prod = 30'(span_delta * signed'({1'b0, span_pos}));
      span_scaled = span_prod / `SRS_MA_SPAN;
      remote_target = srs_ref_t'(remote_ref_4ma + span_scaled[15:0]);
    end
  end

  assign rif.target = sel_remote ? remote_target : notch_tbl[notch_code];
  assign rif.step_up = sel_remote ? raise_step : accel_step;
  assign rif.step_dn = sel_remote ? lower_step : decel_step;
  assign rif.tick = tick;

  srs_ramp u_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .r(rif.ramp)
  );

  // diagnostics and fuel enable
  srs_state_t state;
  srs_state_t next_state;
  logic [3:0] next_code;
  logic next_remote;
  logic next_fuel;

  always_comb begin
    next_state = state;
    unique case (state)
      SRS_DIAG: begin
        if (diag_done) begin
          next_state = diag_pass ? SRS_RUN : SRS_FAILED;
        end
      end
      SRS_RUN: next_state = SRS_RUN;
      SRS_FAILED: next_state = SRS_FAILED;
    endcase
    next_code = sync2[3:0];
    next_remote = sel_remote;
    next_fuel = (state == SRS_RUN) && run_sw
                && !(speed_signal_lost && !ovr_sw);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SRS_DIAG;
      notch_code <= 4'h0;
      remote_active <= 1'b0;
      fuel_enable <= 1'b0;
    end else begin
      state <= next_state;
      notch_code <= next_code;
      remote_active <= next_remote;
      fuel_enable <= next_fuel;
    end
  end

  assign speed_ref = rif.ref_q;
  assign actuator_off = (state == SRS_FAILED);
  assign diag_state = state;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_notch_code;
    1'b1 |=> notch_code == {$past(sync2[3]), $past(sync2[2]), $past(sync2[1]), $past(sync2[0])};
  endproperty
  a_notch_code: assert property (p_notch_code) else $error("notch code bit order wrong");

  property p_pin_to_code;
    $stable(notch_d_pin) [*4] ##0 notch_d_pin |-> notch_code[3];
  endproperty
  a_pin_to_code: assert property (p_pin_to_code) else $error("applied voltage not read as one");

  property p_notch_target;
    !sel_remote |-> rif.target == notch_tbl[notch_code] && rif.step_up == accel_step;
  endproperty
  a_notch_target: assert property (p_notch_target) else $error("notch reference not selected");

  property p_min_fuel;
    !run_sw |=> !fuel_enable;
  endproperty
  a_min_fuel: assert property (p_min_fuel) else $error("fuel enabled without run input");

  property p_speed_loss;
    speed_signal_lost && !ovr_sw |=> !fuel_enable;
  endproperty
  a_speed_loss: assert property (p_speed_loss) else $error("speed loss did not cut fuel");

  property p_override;
    state == SRS_RUN && run_sw && ovr_sw |=> fuel_enable;
  endproperty
  a_override: assert property (p_override) else $error("override did not allow fuel");

  property p_remote_sel;
    !rfail_q && ma_q >= `SRS_MA_SEL |=> remote_active;
  endproperty
  a_remote_sel: assert property (p_remote_sel) else $error("remote not selected at 2 ma");

  property p_low_band;
    sel_remote && ma_q < `SRS_MA_LOW |-> rif.target == remote_ref_4ma;
  endproperty
  a_low_band: assert property (p_low_band) else $error("low band target not 4 ma setpoint");

  sequence s_diag_fail;
    state == SRS_DIAG && diag_done && !diag_pass;
  endsequence
  property p_diag_fail;
    s_diag_fail |=> actuator_off && !fuel_enable ##1 actuator_off && !fuel_enable;
  endproperty
  a_diag_fail: assert property (p_diag_fail) else $error("failed diagnostics left output on");

  property p_tick_period;
    tick |=> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick wider than one cycle");
endmodule : srs_top

// ---- srs_field_model.sv ----
/*
  field side: notch, minimum-fuel and override contacts plus remote transmitter.
  assumes bench commands on clk; a remote sample is offered every fourth cycle.
*/
`timescale 1ns/1ps

module srs_field_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] notch_set,
  input wire logic run_set,
  input wire logic ovr_set,
  input wire srs_pkg::srs_ma_t ma_set,
  output logic [3:0] notch_pins,
  output logic run_pin,
  output logic ovr_pin,
  output logic remote_valid,
  output srs_pkg::srs_ma_t remote_ma
);
  import srs_pkg::*;
  logic [1:0] div;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'h0;
      notch_pins <= 4'h0;
      run_pin <= 1'b0;
      ovr_pin <= 1'b0;
      remote_valid <= 1'b0;
      remote_ma <= 12'h000;
    end else begin
      div <= div + 2'h1;
      notch_pins <= notch_set; // a fallback code stays applied
      run_pin <= run_set; // shutdown use only
      ovr_pin <= ovr_set; // held low while running
      remote_valid <= (div == 2'h3);
      remote_ma <= ma_set;
    end
  end
endmodule : srs_field_model

// ---- tb.sv ----
/*
  self-checking bench of the speed reference selector.
  assumes the field model drives the switch pins and the remote samples.
*/
`timescale 1ns/1ps

module tb;
  import srs_pkg::*;
  localparam int TC = 8;
  logic clk = 1'b0, rst_n = 1'b0, run_set = 1'b0, ovr_set = 1'b0, lost = 1'b0;
  logic diag_done = 1'b0, diag_pass = 1'b0, rfail = 1'b0, table_wr = 1'b0;
  logic [3:0] notch_set = 4'h0, table_idx = 4'h0, pins, notch_code;
  srs_ma_t ma_set = 12'h000, remote_ma;
  srs_ref_t table_data = 16'h0000, speed_ref, ref_v;
  srs_ref_t acc = 16'hffff, dec = 16'h0200, rai = 16'h0400, low = 16'h0100;
  srs_ref_t r4 = 16'h0c00, r20 = 16'h2000;
  logic run_pin, ovr_pin, remote_valid, remote_active, fuel_enable, actuator_off;
  srs_state_t diag_state;
  int errors = 0, tests_run = 0;

  always #5 clk = ~clk;

  srs_field_model field (.clk(clk), .rst_n(rst_n), .notch_set(notch_set), .run_set(run_set),
    .ovr_set(ovr_set), .ma_set(ma_set), .notch_pins(pins), .run_pin(run_pin),
    .ovr_pin(ovr_pin), .remote_valid(remote_valid), .remote_ma(remote_ma));

  srs_top #(.TICK_CYCLES(TC)) dut (.clk(clk), .rst_n(rst_n), .notch_a_pin(pins[0]),
    .notch_b_pin(pins[1]), .notch_c_pin(pins[2]), .notch_d_pin(pins[3]),
    .run_enable_pin(run_pin), .speed_fail_override_pin(ovr_pin), .speed_signal_lost(lost),
    .diag_done(diag_done), .diag_pass(diag_pass), .remote_valid(remote_valid),
    .remote_ma(remote_ma), .remote_fail(rfail), .table_wr(table_wr), .table_idx(table_idx),
    .table_data(table_data), .accel_step(acc), .decel_step(dec), .raise_step(rai),
    .lower_step(low), .remote_ref_4ma(r4), .remote_ref_20ma(r20), .speed_ref(speed_ref),
    .notch_code(notch_code), .remote_active(remote_active), .fuel_enable(fuel_enable),
    .actuator_off(actuator_off), .diag_state(diag_state));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic set_ma(input srs_ma_t v);
    @(posedge clk);
    ma_set <= v;
  endtask : set_ma

  // waits, bounded, for the next ramp step
  task automatic wait_chg;
    #1;
    ref_v = speed_ref;
    for (int i = 0; i < 40 && speed_ref === ref_v; i++) cyc(1);
  endtask : wait_chg

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    #50000;
    errors++;
    summarize();
  end

  initial begin
    cyc(8);
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("speed_ref", 16'h0000, speed_ref);
    chk("diag_state", 16'(SRS_DIAG), 16'(diag_state));
    chk("fuel_enable", 16'h0000, 16'(fuel_enable));
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      table_wr <= 1'b1;
      table_idx <= 4'(i);
      table_data <= 16'((i + 1) << 8);
    end
    @(posedge clk);
    table_wr <= 1'b0;
    diag_done <= 1'b1;
    diag_pass <= 1'b1;
    cyc(1);
    chk("diag_state", 16'(SRS_RUN), 16'(diag_state));
    @(posedge clk);
    run_set <= 1'b1; // engine start waits for diagnostics
    cyc(4);
    chk("fuel_enable", 16'h0001, 16'(fuel_enable));
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      notch_set <= 4'(i);
      cyc(16);
      chk("notch_code", 16'(i), 16'(notch_code));
      chk("speed_ref", 16'((i + 1) << 8), speed_ref);
    end
    $display("test notch done");
    @(posedge clk);
    run_set <= 1'b0;
    cyc(5);
    chk("fuel_enable", 16'h0000, 16'(fuel_enable));
    @(posedge clk);
    run_set <= 1'b1;
    lost <= 1'b1;
    cyc(5);
    chk("fuel_enable", 16'h0000, 16'(fuel_enable));
    @(posedge clk);
    ovr_set <= 1'b1;
    cyc(5);
    chk("fuel_enable", 16'h0001, 16'(fuel_enable));
    @(posedge clk);
    ovr_set <= 1'b0;
    cyc(5);
    chk("fuel_enable", 16'h0000, 16'(fuel_enable));
    $display("test fuel done");
    set_ma(12'h0c7);
    lost <= 1'b0;
    cyc(12);
    chk("remote_active", 16'h0000, 16'(remote_active));
    set_ma(12'h0c8);
    wait_chg();
    chk("remote_active", 16'h0001, 16'(remote_active));
    chk("speed_ref", 16'h0f00, speed_ref);
    cyc(48);
    chk("speed_ref", 16'h0c00, speed_ref);
    set_ma(12'h7d0);
    wait_chg();
    chk("speed_ref", 16'h1000, speed_ref);
    cyc(8);
    chk("speed_ref", 16'h1400, speed_ref);
    cyc(32);
    chk("speed_ref", 16'h2000, speed_ref);
    set_ma(12'h4b0);
    wait_chg();
    chk("speed_ref", 16'h1f00, speed_ref);
    cyc(96);
    chk("speed_ref", 16'h1600, speed_ref);
    set_ma(12'h0c7);
    cyc(16);
    chk("remote_active", 16'h0000, 16'(remote_active));
    chk("speed_ref", 16'h1200, speed_ref); // two decel steps so far
    set_ma(12'h4b0);
    rfail <= 1'b1;
    cyc(16);
    chk("remote_active", 16'h0000, 16'(remote_active));
    chk("speed_ref", 16'h1000, speed_ref);
    @(posedge clk);
    rfail <= 1'b0;
    cyc(12);
    chk("remote_active", 16'h0001, 16'(remote_active));
    $display("test remote done");
    @(posedge clk);
    rst_n <= 1'b0;
    diag_pass <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(6);
    chk("diag_state", 16'(SRS_FAILED), 16'(diag_state));
    chk("actuator_off", 16'h0001, 16'(actuator_off));
    chk("fuel_enable", 16'h0000, 16'(fuel_enable));
    $display("test diagnostics done");
    summarize();
  end
endmodule : tb
